// File: rtl/eccf_ctrl.sv
// Module: exception catch control register, bits 10 down to 3
`default_nettype none
module eccf_ctrl (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        fine_grain_debug_feature,
    input  wire logic        secure_hyp_level_feature,
    input  wire logic        secure_el1_present,
    input  wire logic        secure_el0_present,
    input  wire logic        nonsecure_el2_present,
    input  wire logic        nonsecure_el1_present,
    input  wire logic        el3_present,
    input  wire logic        core_powered,
    input  wire logic        double_lock,
    input  wire logic        os_lock,
    input  wire logic        software_lock,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [11:0] req_addr,
    input  wire logic [31:0] req_wdata,
    input  wire logic [31:0] companion_fields,
    output logic [31:0]      rsp_rdata,
    output logic             rsp_valid,
    output logic             rsp_error,
    output logic             secure_el2_entry_en,
    output logic             secure_el2_return_en,
    output logic             secure_el1_entry_en,
    output logic             secure_el1_return_en,
    output logic             secure_el0_return_en,
    output logic             nonsecure_el2_entry_en,
    output logic             nonsecure_el2_return_en,
    output logic             nonsecure_el1_entry_en,
    output logic             nonsecure_el1_return_en,
    output logic             el3_entry_en,
    output logic             el3_return_en
);
    // Pin-level status passes two flops before use
    logic [3:0] lock_meta_q;
    logic [3:0] lock_sync_q;
    logic [7:0] feat_meta_q;
    logic [7:0] feat_sync_q;
    logic       secure_el2_return_catch_q;
    logic       secure_el1_return_catch_q;
    logic       secure_el0_return_catch_q;
    logic       nonsecure_el2_entry_catch_q;
    logic       nonsecure_el1_entry_catch_q;
    logic       el3_entry_catch_q;
    logic [31:0] rsp_rdata_q;
    logic       rsp_valid_q;
    logic       rsp_error_q;

    wire logic fine;
    wire logic s_el2_ok;
    wire logic s_el1_ok;
    wire logic s_el0_ok;
    wire logic ns_el2_ok;
    wire logic ns_el1_ok;
    wire logic el3_ok;
    wire logic hit;
    wire logic do_write;
    wire logic [31:0] read_word;
    wire logic [31:0] next_err;
    eccf_pkg::eccf_access_type access_mode;

    always_ff @(posedge clock) begin
        lock_meta_q <= {core_powered, double_lock, os_lock, software_lock};
        lock_sync_q <= lock_meta_q;
        feat_meta_q <= {2'h0, fine_grain_debug_feature,
                        secure_hyp_level_feature, secure_el1_present,
                        secure_el0_present, nonsecure_el2_present,
                        nonsecure_el1_present};
        feat_sync_q <= {feat_meta_q[7:6], feat_meta_q[5:0]};
    end

    // Feature qualifiers; el3 kept separate below
    assign fine      = feat_sync_q[5];
    assign s_el2_ok  = fine & feat_sync_q[4];
    assign s_el1_ok  = fine & feat_sync_q[3];
    assign s_el0_ok  = fine & feat_sync_q[2];
    assign ns_el2_ok = feat_sync_q[1];
    assign ns_el1_ok = feat_sync_q[0];

    logic el3_meta_q;
    logic el3_sync_q;
    always_ff @(posedge clock) begin
        el3_meta_q <= el3_present;
        el3_sync_q <= el3_meta_q;
    end
    // Coarse EL3 form lives below bit 3, outside this block
    assign el3_ok = fine & el3_sync_q;

    // access class from power and lock state
    always_comb begin
        if (!lock_sync_q[3] || lock_sync_q[2] || lock_sync_q[1]) begin
            access_mode = eccf_pkg::ECCF_ACC_ERROR;
        end else if (lock_sync_q[0]) begin
            access_mode = eccf_pkg::ECCF_ACC_RO;
        end else begin
            access_mode = eccf_pkg::ECCF_ACC_RW;
        end
    end

    assign hit      = req_valid && (req_addr == eccf_pkg::ECCF_REG_OFFSET);
    assign do_write = hit && req_write &&
                      (access_mode == eccf_pkg::ECCF_ACC_RW);

    // reserved bits 7 and 4 always read zero
    assign read_word = {21'h0,
        secure_el2_return_catch_q & s_el2_ok,
        secure_el1_return_catch_q & s_el1_ok,
        secure_el0_return_catch_q & s_el0_ok,
        1'b0,
        nonsecure_el2_entry_catch_q & ns_el2_ok,
        nonsecure_el1_entry_catch_q & ns_el1_ok,
        1'b0,
        el3_entry_catch_q & el3_ok,
        3'h0};
    assign next_err = 32'h0;

    always_ff @(posedge clock) begin
        if (srst) begin
            secure_el2_return_catch_q   <= 1'b0;
            secure_el1_return_catch_q   <= 1'b0;
            secure_el0_return_catch_q   <= 1'b0;
            nonsecure_el2_entry_catch_q <= 1'b0;
            nonsecure_el1_entry_catch_q <= 1'b0;
            el3_entry_catch_q           <= 1'b0;
        end else if (do_write) begin
            secure_el2_return_catch_q   <=
                req_wdata[eccf_pkg::SEC_EL2_RET_BIT] & s_el2_ok;
            secure_el1_return_catch_q   <=
                req_wdata[eccf_pkg::SEC_EL1_RET_BIT] & s_el1_ok;
            secure_el0_return_catch_q   <=
                req_wdata[eccf_pkg::SEC_EL0_RET_BIT] & s_el0_ok;
            nonsecure_el2_entry_catch_q <=
                req_wdata[eccf_pkg::NS_EL2_ENT_BIT] & ns_el2_ok;
            nonsecure_el1_entry_catch_q <=
                req_wdata[eccf_pkg::NS_EL1_ENT_BIT] & ns_el1_ok;
            el3_entry_catch_q           <=
                req_wdata[eccf_pkg::EL3_ENT_BIT] & el3_ok;
        end
    end

    // Response one cycle after a hit; miss gives no response
    always_ff @(posedge clock) begin
        if (srst) begin
            rsp_valid_q <= 1'b0;
            rsp_error_q <= 1'b0;
            rsp_rdata_q <= 32'h0;
        end else begin
            rsp_valid_q <= hit;
            rsp_error_q <= hit && (access_mode == eccf_pkg::ECCF_ACC_ERROR);
            rsp_rdata_q <= (hit && !req_write &&
                            access_mode != eccf_pkg::ECCF_ACC_ERROR)
                           ? read_word : next_err;
        end
    end
    assign rsp_valid = rsp_valid_q;
    assign rsp_error = rsp_error_q;
    assign rsp_rdata = rsp_rdata_q;

    eccf_pair_decode u_s_el2 (
        .entry_bit         (companion_fields[eccf_pkg::SEC_EL2_ENT_BIT]),
        .return_bit        (secure_el2_return_catch_q),
        .fine_grain        (1'b1),
        .level_present     (s_el2_ok),
        .catch_entry       (secure_el2_entry_en),
        .catch_reset_entry (),
        .catch_return      (secure_el2_return_en)
    );
    eccf_pair_decode u_s_el1 (
        .entry_bit         (companion_fields[eccf_pkg::SEC_EL1_ENT_BIT]),
        .return_bit        (secure_el1_return_catch_q),
        .fine_grain        (1'b1),
        .level_present     (s_el1_ok),
        .catch_entry       (secure_el1_entry_en),
        .catch_reset_entry (),
        .catch_return      (secure_el1_return_en)
    );
    assign secure_el0_return_en = secure_el0_return_catch_q & s_el0_ok;
    eccf_pair_decode u_ns_el2 (
        .entry_bit         (nonsecure_el2_entry_catch_q),
        .return_bit        (companion_fields[eccf_pkg::NS_EL2_RET_BIT]),
        .fine_grain        (fine),
        .level_present     (ns_el2_ok),
        .catch_entry       (nonsecure_el2_entry_en),
        .catch_reset_entry (),
        .catch_return      (nonsecure_el2_return_en)
    );
    eccf_pair_decode u_ns_el1 (
        .entry_bit         (nonsecure_el1_entry_catch_q),
        .return_bit        (companion_fields[eccf_pkg::NS_EL1_RET_BIT]),
        .fine_grain        (fine),
        .level_present     (ns_el1_ok),
        .catch_entry       (nonsecure_el1_entry_en),
        .catch_reset_entry (),
        .catch_return      (nonsecure_el1_return_en)
    );
    // EL3 pair; reset entry shares entry enable
    eccf_pair_decode u_el3 (
        .entry_bit         (el3_entry_catch_q),
        .return_bit        (companion_fields[eccf_pkg::EL3_RET_BIT]),
        .fine_grain        (1'b1),
        .level_present     (el3_ok),
        .catch_entry       (el3_entry_en),
        .catch_reset_entry (),
        .catch_return      (el3_return_en)
    );

    a_reset_clears: assert property (
        @(posedge clock)
        srst |=> !nonsecure_el2_entry_catch_q && !el3_entry_catch_q
                 && !secure_el2_return_catch_q)
        else $error("fields not cleared by reset");
    a_reserved_zero: assert property (
        @(posedge clock) disable iff (srst)
        rsp_valid |-> rsp_rdata[7] == 1'b0 && rsp_rdata[4] == 1'b0)
        else $error("reserved bit read nonzero");
    a_error_locked: assert property (
        @(posedge clock) disable iff (srst)
        hit && access_mode == eccf_pkg::ECCF_ACC_ERROR
        |=> rsp_valid && rsp_error)
        else $error("locked access did not error");
    a_ro_no_write: assert property (
        @(posedge clock) disable iff (srst)
        hit && req_write && access_mode == eccf_pkg::ECCF_ACC_RO
        |=> $stable(el3_entry_catch_q) && $stable(secure_el0_return_catch_q))
        else $error("write under software lock took effect");
    a_s_el0_ret: assert property (
        @(posedge clock) disable iff (srst)
        secure_el0_return_en |-> secure_el0_return_catch_q)
        else $error("secure el0 return without field");
    a_absent_inert: assert property (
        @(posedge clock) disable iff (srst)
        !ns_el2_ok |-> !nonsecure_el2_entry_en && !nonsecure_el2_return_en)
        else $error("absent level enabled catch");
    a_coarse_ns1: assert property (
        @(posedge clock) disable iff (srst)
        !fine && ns_el1_ok |->
        nonsecure_el1_return_en == nonsecure_el1_entry_catch_q)
        else $error("coarse ns el1 mismatch");
    a_fine_el3: assert property (
        @(posedge clock) disable iff (srst)
        el3_ok && el3_entry_catch_q &&
        companion_fields[eccf_pkg::EL3_RET_BIT] |-> !el3_return_en)
        else $error("el3 both set still caught return");
    a_write_lands: assert property (
        @(posedge clock) disable iff (srst)
        do_write && req_wdata[eccf_pkg::NS_EL2_ENT_BIT] && ns_el2_ok
        |=> nonsecure_el2_entry_catch_q)
        else $error("write did not land");
    c_rw_write: cover property (@(posedge clock) do_write);
    c_error: cover property (@(posedge clock) rsp_error);
    c_fine_ret: cover property (@(posedge clock) el3_return_en);
endmodule
`default_nettype wire

// File: rtl/eccf_pkg.sv
// Package: exception catch control register layout and encodings
`default_nettype none
package eccf_pkg;
    localparam logic [11:0] ECCF_REG_OFFSET = 12'h098;
    localparam logic [31:0] ECCF_RESET_VALUE = 32'h0000_0000;
    // Bit positions of the fields held here
    localparam int SEC_EL2_RET_BIT = 10;
    localparam int SEC_EL1_RET_BIT = 9;
    localparam int SEC_EL0_RET_BIT = 8;
    localparam int NS_EL3_RSV_BIT  = 7;
    localparam int NS_EL2_ENT_BIT  = 6;
    localparam int NS_EL1_ENT_BIT  = 5;
    localparam int NS_EL0_RSV_BIT  = 4;
    localparam int EL3_ENT_BIT     = 3;
    // Fields outside bits 10:3 supplied from companion inputs
    localparam int SEC_EL2_ENT_BIT = 2;
    localparam int SEC_EL1_ENT_BIT = 1;
    localparam int NS_EL2_RET_BIT  = 14;
    localparam int NS_EL1_RET_BIT  = 13;
    localparam int EL3_RET_BIT     = 11;
    localparam logic [31:0] ECCF_FIELD_MASK = 32'h0000_0768;
    typedef enum logic [1:0] {
        ECCF_ACC_ERROR,
        ECCF_ACC_RO,
        ECCF_ACC_RW
    } eccf_access_type;
endpackage
`default_nettype wire

// File: rtl/eccf_pair_decode.sv
// Module: decodes one entry/return field pair into catch enables
`default_nettype none
module eccf_pair_decode (
    input  wire logic entry_bit,
    input  wire logic return_bit,
    input  wire logic fine_grain,
    input  wire logic level_present,
    output logic      catch_entry,
    output logic      catch_reset_entry,
    output logic      catch_return
);
    wire logic fine_entry;
    wire logic fine_return;
    // Entry set: entry and reset entry; return follows only when ret clear
    assign fine_entry  = entry_bit;
    assign fine_return = entry_bit ^ return_bit;
    // Coarse mode: entry bit alone opens every catch kind
    assign catch_entry       = level_present &
                               (fine_grain ? fine_entry : entry_bit);
    assign catch_reset_entry = catch_entry;
    assign catch_return      = level_present &
                               (fine_grain ? fine_return : entry_bit);
endmodule
`default_nettype wire

// File: test/eccf_debugger.sv
// External debugger model driving the register access port
`default_nettype none
module eccf_debugger (
    input  wire logic   clock,
    output logic        req_valid,
    output logic        req_write,
    output logic [11:0] req_addr,
    output logic [31:0] req_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr  = 12'h000;
        req_wdata = 32'h0000_0000;
    end
    // offset chosen by caller
    // One request per call, held until the next access or idle call
    task automatic access(input logic w, input logic [11:0] a,
                          input logic [31:0] d);
        @(negedge clock);
        req_valid = 1'b1;
        req_write = w;
        req_addr  = a;
        req_wdata = d;
    endtask
    // Released lines show the inverse, never a stale copy
    task automatic idle();
        @(negedge clock);
        req_valid = 1'b0;
        req_write = ~req_write;
        req_addr  = ~req_addr;
        req_wdata = ~req_wdata;
    endtask
endmodule
`default_nettype wire

// File: test/eccf_ctrl_bench.sv
// Self-checking bench for the exception catch control block
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module eccf_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, srst, fine, sel2, s1, s0, ns2, ns1, el3;
    logic        pwr, dlk, olk, slk, req_valid, req_write;
    logic        rsp_valid, rsp_error, e, r;
    logic [11:0] req_addr, a;
    logic [31:0] req_wdata, comp, rsp_rdata, v;
    logic [31:0] rnd = 32'h0001_2052;
    logic [10:0] en;
    logic [10:0] errs[3] = '{11'h7f0, 11'h7fc, 11'h7fa};
    logic [64:0] exp_q[$];
    logic [64:0] n;
    int          mismatches, n_checks, cycles;

    eccf_debugger dbg (.clock(clock), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata));
    eccf_ctrl uut (.clock(clock), .srst(srst),
        .fine_grain_debug_feature(fine), .secure_hyp_level_feature(sel2),
        .secure_el1_present(s1), .secure_el0_present(s0),
        .nonsecure_el2_present(ns2), .nonsecure_el1_present(ns1),
        .el3_present(el3), .core_powered(pwr), .double_lock(dlk),
        .os_lock(olk), .software_lock(slk), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .companion_fields(comp), .rsp_rdata(rsp_rdata),
        .rsp_valid(rsp_valid), .rsp_error(rsp_error),
        .secure_el2_entry_en(en[10]), .secure_el2_return_en(en[9]),
        .secure_el1_entry_en(en[8]), .secure_el1_return_en(en[7]),
        .secure_el0_return_en(en[6]), .nonsecure_el2_entry_en(en[5]),
        .nonsecure_el2_return_en(en[4]), .nonsecure_el1_entry_en(en[3]),
        .nonsecure_el1_return_en(en[2]), .el3_entry_en(en[1]),
        .el3_return_en(en[0]));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Note the expected answer, then issue the access
    task automatic acc(input logic w, input logic [31:0] d, input logic er,
                       input logic [31:0] m, input logic [31:0] ev);
        exp_q.push_back({er, m, ev});
        rnd = xs(rnd);
        dbg.access(w, eccf_pkg::ECCF_REG_OFFSET, w ? d : rnd);
    endtask
    task automatic gap(input int k);
        dbg.idle();
        repeat (k) @(negedge clock);
    endtask
    // Strap and lock changes need two cycles through the synchronisers
    task automatic straps(input logic [10:0] s);
        @(negedge clock);
        {fine, sel2, s1, s0, ns2, ns1, el3, pwr, dlk, olk, slk} = s;
        repeat (4) @(negedge clock);
    endtask

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            give_verdict();
        end
    end
    // Every answer consumes the oldest note; a stray answer is an error
    always @(negedge clock) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK(rsp_valid, 1'b0)
            end else begin
                n = exp_q.pop_front();
                `CHK(rsp_error, n[64])
                `CHK(rsp_rdata & n[63:32], n[31:0])
            end
        end
    end

    initial begin
        srst = 1'b1;
        comp = 32'h0000_0000;
        {fine, sel2, s1, s0, ns2, ns1, el3, pwr, dlk, olk, slk} = 11'h7f8;
        repeat (6) @(negedge clock);
        srst = 1'b0;
        repeat (3) @(negedge clock);
        acc(1'b0, 0, 1'b0, 32'h7f8, 32'h0);
        gap(1);
        `CHK(en, 11'h000)
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            {r, e} = k[1:0];
            rnd = xs(rnd);
            comp = {17'h0, r, r, 1'b0, r, 8'h00, e, e, 1'b0};
            v = {21'h0, r, r, r, 1'b0, e, e, 1'b0, e, 3'h0};
            acc(1'b1, (rnd & ~32'h7f8) | v | 32'h90, 1'b0, '1, 0);
            acc(1'b0, 0, 1'b0, 32'h7f8, v);
            gap(1);
            `CHK(en, {e, e^r, e, e^r, r, e, e^r, e, e^r, e, e^r})
        end
        $display("test pair decode done");
        straps(11'h768);
        comp = 32'h0000_6806;
        acc(1'b1, '1, 1'b0, '1, 0);
        acc(1'b0, 0, 1'b0, 32'h7f8, 32'h660);
        gap(1);
        `CHK(en, 11'h528)
        straps(11'h3f8);
        acc(1'b1, '1, 1'b0, '1, 0);
        acc(1'b0, 0, 1'b0, 32'h7f8, 32'h060);
        gap(1);
        `CHK(en & 11'h67c, 11'h03c)
        acc(1'b1, 0, 1'b0, '1, 0);
        gap(1);
        `CHK(en & 11'h67c, 11'h000)
        $display("test absent and coarse done");
        straps(11'h7f8);
        acc(1'b1, '1, 1'b0, '1, 0);
        gap(0);
        straps(11'h7f9);
        acc(1'b1, 0, 1'b0, '1, 0);
        acc(1'b0, 0, 1'b0, 32'h7f8, 32'h768);
        gap(0);
        foreach (errs[i]) begin
            straps(errs[i]);
            acc(1'b0, 0, 1'b1, '1, 0);
            acc(1'b1, 0, 1'b1, '1, 0);
            gap(0);
        end
        straps(11'h7f8);
        rnd = xs(rnd);
        a = (rnd[11:0] == 12'h098) ? 12'h09c : rnd[11:0];
        dbg.access(1'b1, a, 32'h0000_0000);
        dbg.access(1'b0, 12'h09c, rnd);
        acc(1'b0, 0, 1'b0, 32'h7f8, 32'h768);
        gap(3);
        `CHK(exp_q.size(), 0)
        $display("test locks and decode done");
        give_verdict();
    end
endmodule
`undef CHK
`default_nettype wire
